/* File: jtpg_pkg.sv */
// package: constants and carriers for the link test pattern generator
package jtpg_pkg;
    // ==================================================
    // register map
    localparam logic [11:0] JTPG_ADDR_SYNC_CTRL = 12'h572;
    localparam logic [11:0] JTPG_ADDR_IF_TEST = 12'h573;
    localparam logic [11:0] JTPG_ADDR_LL_TEST = 12'h574;
    localparam logic [11:0] JTPG_ADDR_UP_BASE = 12'h551;
    localparam logic [11:0] JTPG_ADDR_UP_LAST = 12'h558;
    localparam logic [7:0] JTPG_RST_SYNC_CTRL = 8'h00;
    localparam logic [7:0] JTPG_RST_IF_TEST = 8'h00;
    localparam logic [7:0] JTPG_RST_LL_TEST = 8'h00;
    localparam logic [7:0] JTPG_SYNC_DISABLE = 8'hC0;
    localparam int JTPG_MODE_LSB = 0;
    localparam int JTPG_POINT_LSB = 4;
    localparam int JTPG_LL_LSB = 0;
    // ==================================================
    // modes and insertion points
    localparam logic [3:0] JTPG_M_OFF = 4'h0;
    localparam logic [3:0] JTPG_M_CHECKER = 4'h1;
    localparam logic [3:0] JTPG_M_TOGGLE = 4'h2;
    localparam logic [3:0] JTPG_M_PN31 = 4'h3;
    localparam logic [3:0] JTPG_M_PRBS_TWENTYTHREE_BIT = 4'h4;
    localparam logic [3:0] JTPG_M_PN15 = 4'h5;
    localparam logic [3:0] JTPG_M_PN9 = 4'h6;
    localparam logic [3:0] JTPG_M_PN7 = 4'h7;
    localparam logic [3:0] JTPG_M_RAMP = 4'h8;
    localparam logic [3:0] JTPG_M_USER_REP = 4'hE;
    localparam logic [3:0] JTPG_M_USER_ONE = 4'hF;
    localparam logic [1:0] JTPG_P_SAMPLE = 2'h0;
    localparam logic [1:0] JTPG_P_SYMBOL = 2'h1;
    localparam logic [1:0] JTPG_P_OCTET = 2'h2;
    localparam logic [15:0] JTPG_CHECK_A = 16'h5555;
    localparam logic [15:0] JTPG_CHECK_B = 16'hAAAA;
    // ==================================================
    // prbs seeds
    localparam logic [30:0] JTPG_SEED_PN31 = 31'h0003AFFF;
    localparam logic [22:0] JTPG_SEED_PRBS_TWENTYTHREE_BIT = 23'h003AFF;
    localparam logic [14:0] JTPG_SEED_PN15 = 15'h03AF;
    localparam logic [8:0] JTPG_SEED_PN9 = 9'h092;
    localparam logic [6:0] JTPG_SEED_PN7 = 7'h07;
    // ==================================================
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [7:0] wdata;
    } jtpg_reg_req_t;
    typedef struct packed {
        logic [15:0] s00;
        logic [15:0] s01;
        logic [15:0] s10;
        logic [15:0] s11;
    } jtpg_frame_t;
endpackage

/* File: jtpg_lfsr.sv */
// one fibonacci prbs generator, reloads its seed on request
`timescale 1ns/1ps
module jtpg_lfsr #(
    parameter int W = 9,
    parameter int TAP = 5,
    parameter logic [W-1:0] SEED = '1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_load,
    input wire logic i_step,
    // pattern out
    output logic [W-1:0] o_state
);
    typedef struct packed {
        logic [W-1:0] sr;
    } jtpg_lfsr_st_t;
    jtpg_lfsr_st_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (i_load) begin
            st_d.sr = SEED;
        end else if (i_step) begin
            st_d.sr = {st_q.sr[W-2:0], st_q.sr[W-1] ^ st_q.sr[TAP-1]};
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= SEED;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_state = st_q.sr;
endmodule

/* File: jtpg_top.sv */
// link test pattern generator with its register slice
`timescale 1ns/1ps
module jtpg_top
    import jtpg_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // register port
    input wire jtpg_reg_req_t i_reg,
    output logic [7:0] o_rdata,
    output logic o_rvalid,
    // datapath in, one beat per cycle at each point
    input wire jtpg_frame_t i_frame,
    input wire logic i_frame_vld,
    input wire logic [9:0] i_symbol,
    input wire logic i_symbol_vld,
    input wire logic [7:0] i_octet,
    input wire logic i_octet_vld,
    // datapath out
    output jtpg_frame_t o_frame,
    output logic o_frame_vld,
    output logic [9:0] o_symbol,
    output logic o_symbol_vld,
    output logic [7:0] o_octet,
    output logic o_octet_vld,
    // link layer test and sync control
    output logic [2:0] o_ll_test_sel,
    output logic o_sync_req_disable
);
    // ==================================================
    // state
    typedef struct packed {
        logic [7:0] sync_ctrl;
        logic [7:0] if_test;
        logic [7:0] ll_test;
        logic [7:0][7:0] user;
        logic [3:0] mode_prev;
        logic [15:0] ramp;
        logic [1:0] uidx;
        logic ufin;
        logic phase;
        logic [7:0] rdata;
        logic rvalid;
        jtpg_frame_t frame;
        logic frame_vld;
        logic [9:0] symbol;
        logic symbol_vld;
        logic [7:0] octet;
        logic octet_vld;
    } jtpg_st_t;
    jtpg_st_t st_q, st_d;

    logic [3:0] mode;
    logic [1:0] point;
    logic step;
    logic fresh;
    logic [30:0] pn31;
    logic [22:0] prbs_twentythree_bit;
    logic [14:0] pn15;
    logic [8:0] pn9;
    logic [6:0] pn7;
    logic [15:0] pat;
    logic [15:0] uword;

    assign mode = st_q.if_test[JTPG_MODE_LSB +: 4];
    assign point = st_q.if_test[JTPG_POINT_LSB +: 2];
    // the pattern only moves on a beat of the chosen point
    assign step = (point == JTPG_P_SAMPLE) ? i_frame_vld :
                  (point == JTPG_P_SYMBOL) ? i_symbol_vld :
                  (point == JTPG_P_OCTET) ? i_octet_vld : 1'b0;
    assign fresh = (mode != st_q.mode_prev);
    assign uword = {st_q.user[{st_q.uidx, 1'b0}], st_q.user[{st_q.uidx, 1'b1}]};

    // ==================================================
    // prbs generators, seeded on a new mode selection
    jtpg_lfsr #(.W(31), .TAP(28), .SEED(JTPG_SEED_PN31)) u_pn31 (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_load(fresh), .i_step(step && mode == JTPG_M_PN31), .o_state(pn31));
    jtpg_lfsr #(.W(23), .TAP(18), .SEED(JTPG_SEED_PRBS_TWENTYTHREE_BIT)) u_prbs_twentythree_bit (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_load(fresh), .i_step(step && mode == JTPG_M_PRBS_TWENTYTHREE_BIT), .o_state(prbs_twentythree_bit));
    jtpg_lfsr #(.W(15), .TAP(14), .SEED(JTPG_SEED_PN15)) u_pn15 (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_load(fresh), .i_step(step && mode == JTPG_M_PN15), .o_state(pn15));
    jtpg_lfsr #(.W(9), .TAP(5), .SEED(JTPG_SEED_PN9)) u_pn9 (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_load(fresh), .i_step(step && mode == JTPG_M_PN9), .o_state(pn9));
    jtpg_lfsr #(.W(7), .TAP(6), .SEED(JTPG_SEED_PN7)) u_pn7 (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
        .i_load(fresh), .i_step(step && mode == JTPG_M_PN7), .o_state(pn7));

    // ==================================================
    // current pattern word, msb aligned at 16 bits
    always_comb begin
        pat = 16'h0000;
        case (mode)
            JTPG_M_CHECKER: pat = st_q.phase ? JTPG_CHECK_B : JTPG_CHECK_A;
            JTPG_M_TOGGLE: pat = {16{st_q.phase}};
            JTPG_M_PN31: pat = pn31[30:15];
            JTPG_M_PRBS_TWENTYTHREE_BIT: pat = prbs_twentythree_bit[22:7];
            JTPG_M_PN15: pat = {pn15, 1'b0};
            JTPG_M_PN9: pat = {pn9, 7'h00};
            JTPG_M_PN7: pat = {pn7, 9'h000};
            JTPG_M_USER_REP: pat = uword;
            JTPG_M_USER_ONE: pat = st_q.ufin ? 16'h0000 : uword;
            default: pat = 16'h0000;
        endcase
    end

    // ==================================================
    // registers, sequencing and output muxing
    always_comb begin
        st_d = st_q;
        st_d.rvalid = 1'b0;
        st_d.mode_prev = mode;
        // register writes; unmapped addresses are ignored
        if (i_reg.wr) begin
            if (i_reg.addr == JTPG_ADDR_SYNC_CTRL) begin
                st_d.sync_ctrl = i_reg.wdata;
            end else if (i_reg.addr == JTPG_ADDR_IF_TEST) begin
                st_d.if_test = i_reg.wdata;
            end else if (i_reg.addr == JTPG_ADDR_LL_TEST) begin
                st_d.ll_test = i_reg.wdata;
            end else if (i_reg.addr >= JTPG_ADDR_UP_BASE && i_reg.addr <= JTPG_ADDR_UP_LAST) begin
                st_d.user[3'(i_reg.addr - JTPG_ADDR_UP_BASE)] = i_reg.wdata;
            end
        end
        // reads answer one cycle later; unmapped reads return zero
        if (i_reg.rd) begin
            st_d.rvalid = 1'b1;
            if (i_reg.addr == JTPG_ADDR_SYNC_CTRL) begin
                st_d.rdata = st_q.sync_ctrl;
            end else if (i_reg.addr == JTPG_ADDR_IF_TEST) begin
                st_d.rdata = st_q.if_test;
            end else if (i_reg.addr == JTPG_ADDR_LL_TEST) begin
                st_d.rdata = st_q.ll_test;
            end else if (i_reg.addr >= JTPG_ADDR_UP_BASE && i_reg.addr <= JTPG_ADDR_UP_LAST) begin
                st_d.rdata = st_q.user[3'(i_reg.addr - JTPG_ADDR_UP_BASE)];
            end else begin
                st_d.rdata = 8'h00;
            end
        end
        // sequence state restarts on each new mode
        if (fresh) begin
            st_d.ramp = 16'h0000;
            st_d.uidx = 2'd0;
            st_d.ufin = 1'b0;
            st_d.phase = 1'b0;
        end else if (step) begin
            st_d.ramp = st_q.ramp + 16'h0001;
            st_d.phase = ~st_q.phase;
            st_d.uidx = st_q.uidx + 2'd1;
            if (st_q.uidx == 2'd3) begin
                st_d.ufin = 1'b1;
            end
        end
        // datapath: registered pass or replace, one cycle latency
        st_d.frame_vld = i_frame_vld;
        st_d.symbol_vld = i_symbol_vld;
        st_d.octet_vld = i_octet_vld;
        st_d.frame = i_frame;
        st_d.symbol = i_symbol;
        st_d.octet = i_octet;
        if (mode != JTPG_M_OFF) begin
            if (point == JTPG_P_SAMPLE) begin
                // every converter and sample of the frame carries one value
                if (mode == JTPG_M_RAMP) begin
                    st_d.frame = {4{st_q.ramp}};
                end else begin
                    st_d.frame = {4{pat}};
                end
            end else if (point == JTPG_P_SYMBOL) begin
                st_d.symbol = (mode == JTPG_M_RAMP) ? st_q.ramp[9:0] : pat[15:6];
            end else if (point == JTPG_P_OCTET) begin
                // user slice 15:9 is seven bits, placed low with a zero msb
                if (mode == JTPG_M_RAMP) begin
                    st_d.octet = st_q.ramp[7:0];
                end else if (mode == JTPG_M_USER_REP || mode == JTPG_M_USER_ONE) begin
                    st_d.octet = {1'b0, pat[15:9]};
                end else begin
                    st_d.octet = pat[15:8];
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
            st_q.sync_ctrl <= JTPG_RST_SYNC_CTRL;
            st_q.if_test <= JTPG_RST_IF_TEST;
            st_q.ll_test <= JTPG_RST_LL_TEST;
        end else begin
            st_q <= st_d;
        end
    end

    // ==================================================
    // outputs from flip-flops; o_sync_req_disable is decoded from sync_ctrl
    assign o_rdata = st_q.rdata;
    assign o_rvalid = st_q.rvalid;
    assign o_frame = st_q.frame;
    assign o_frame_vld = st_q.frame_vld;
    assign o_symbol = st_q.symbol;
    assign o_symbol_vld = st_q.symbol_vld;
    assign o_octet = st_q.octet;
    assign o_octet_vld = st_q.octet_vld;
    assign o_ll_test_sel = st_q.ll_test[JTPG_LL_LSB +: 3];
    // host disables sync request before link layer tests
    assign o_sync_req_disable = (st_q.sync_ctrl == JTPG_SYNC_DISABLE);
endmodule

/* File: jtpg_top_asserts.sv */
// port checker for the link test pattern generator, bound to its top
`timescale 1ns/1ps
module jtpg_top_asserts
    import jtpg_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // register port
    input wire jtpg_reg_req_t i_reg,
    input wire logic o_rvalid,
    input wire logic [2:0] o_ll_test_sel,
    input wire logic o_sync_req_disable,
    // datapath
    input wire logic i_frame_vld,
    input wire jtpg_frame_t o_frame,
    input wire logic o_frame_vld,
    input wire logic [9:0] i_symbol,
    input wire logic i_symbol_vld,
    input wire logic [9:0] o_symbol,
    input wire logic o_symbol_vld,
    input wire logic [7:0] o_octet,
    input wire logic o_octet_vld
);
    // ==========
    // shadow of the select register, three deep so restarts are skipped
    typedef struct packed {
        logic [5:0] sel;
        logic [5:0] prev;
        logic [5:0] prev2;
    } jtpg_chk_t;
    jtpg_chk_t st_q, st_d;
    logic steady;
    always_comb begin
        st_d = st_q;
        st_d.prev = st_q.sel;
        st_d.prev2 = st_q.prev;
        if (i_reg.wr && i_reg.addr == JTPG_ADDR_IF_TEST) begin
            st_d.sel = i_reg.wdata[5:0];
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign steady = (st_q.sel == st_q.prev) && (st_q.prev == st_q.prev2);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence sym_chk;
        o_symbol_vld && steady && st_q.sel == {JTPG_P_SYMBOL, JTPG_M_CHECKER};
    endsequence
    sequence oct_ramp;
        o_octet_vld && steady && st_q.sel == {JTPG_P_OCTET, JTPG_M_RAMP};
    endsequence
    // ==========
    // assertions
    chk_rvalid_after_rd: assert property (i_reg.rd |=> o_rvalid)
        else $error("read strobe gave no read valid");
    chk_rvalid_cause: assert property (o_rvalid |-> $past(i_reg.rd))
        else $error("read valid without a read");
    chk_frame_lat: assert property (i_frame_vld |=> o_frame_vld)
        else $error("frame beat lost");
    chk_symbol_lat: assert property (o_symbol_vld |-> $past(i_symbol_vld))
        else $error("symbol beat from nowhere");
    chk_pass_off: assert property ((st_q.sel[3:0] == JTPG_M_OFF && steady && i_symbol_vld)
        |=> o_symbol == $past(i_symbol))
        else $error("symbol not passed through with mode off");
    chk_frame_equal: assert property ((o_frame_vld && steady && st_q.sel[3:0] != JTPG_M_OFF
        && st_q.sel[5:4] == JTPG_P_SAMPLE) |-> o_frame.s00 == o_frame.s01
        && o_frame.s00 == o_frame.s10 && o_frame.s00 == o_frame.s11)
        else $error("samples of one frame differ");
    chk_check_alt: assert property (sym_chk ##1 sym_chk |->
        o_symbol == ~$past(o_symbol) && o_symbol inside {10'h155, 10'h2AA})
        else $error("symbol checkerboard broken");
    chk_ramp_step: assert property (oct_ramp ##1 oct_ramp |->
        o_octet == $past(o_octet) + 8'h01)
        else $error("octet ramp did not step by one");
    chk_ll_follow: assert property ((i_reg.wr && i_reg.addr == JTPG_ADDR_LL_TEST)
        |=> o_ll_test_sel == $past(i_reg.wdata[2:0]))
        else $error("link layer select did not follow write");
    chk_sync_off: assert property ((i_reg.wr && i_reg.addr == JTPG_ADDR_SYNC_CTRL
        && i_reg.wdata == JTPG_SYNC_DISABLE) |=> o_sync_req_disable)
        else $error("sync request not disabled");
    cover property (o_rvalid);
    cover property (sym_chk ##1 sym_chk);
    cover property (oct_ramp ##1 oct_ramp);
endmodule
bind jtpg_top jtpg_top_asserts i_chk (.*);

/* File: jtpg_rx_model.sv */
// link receiver model: captures lane words at the tapped point
`timescale 1ns/1ps
module jtpg_rx_model
    import jtpg_pkg::*;
(
    // clock and control
    input wire logic i_ref_clk,
    input wire logic i_clr,
    input wire logic [1:0] i_point,
    // lane data from the generator
    input wire jtpg_frame_t i_frame,
    input wire logic i_frame_vld,
    input wire logic [9:0] i_symbol,
    input wire logic i_symbol_vld,
    input wire logic [7:0] i_octet,
    input wire logic i_octet_vld,
    // captured words
    output logic [15:0] o_cap [8],
    output logic [3:0] o_cnt
);
    logic hit;
    logic [15:0] word;
    always_comb begin
        hit = i_octet_vld;
        word = {8'h00, i_octet};
        if (i_point == JTPG_P_SAMPLE) begin
            hit = i_frame_vld;
            word = i_frame.s00;
        end else if (i_point == JTPG_P_SYMBOL) begin
            hit = i_symbol_vld;
            word = {6'h00, i_symbol};
        end
    end
    // a real receiver cannot stall the lane, so neither does this one
    always_ff @(posedge i_ref_clk) begin
        if (i_clr) begin
            o_cnt <= 4'h0;
        end else if (hit && o_cnt < 4'h8) begin
            o_cap[o_cnt[2:0]] <= word;
            o_cnt <= o_cnt + 4'h1;
        end
    end
endmodule

/* File: jtpg_top_test.sv */
// self-checking bench for the link test pattern generator
`timescale 1ns/1ps
module jtpg_top_test import jtpg_pkg::*;;
    logic i_ref_clk, i_rst_n, clr, i_frame_vld, i_symbol_vld, i_octet_vld;
    logic o_rvalid, o_frame_vld, o_symbol_vld, o_octet_vld, o_sync_req_disable;
    jtpg_reg_req_t i_reg;
    jtpg_frame_t i_frame, o_frame;
    logic [9:0] i_symbol, o_symbol;
    logic [7:0] i_octet, o_octet, o_rdata;
    logic [2:0] o_ll_test_sel;
    logic [3:0] cnt;
    logic [15:0] cap [8];
    logic [15:0] first [8];
    logic [15:0] up [4] = '{16'hA5C3, 16'h1234, 16'hFFC0, 16'h8001};
    int errors = 0;
    int n_checks = 0;
    // select, then six expected words at the tap
    logic [101:0] rows [10] = '{
        {JTPG_P_SAMPLE, JTPG_M_CHECKER, {3{16'h5555, 16'hAAAA}}},
        {JTPG_P_SAMPLE, JTPG_M_TOGGLE, {3{16'h0000, 16'hFFFF}}},
        {JTPG_P_SYMBOL, JTPG_M_CHECKER, {3{16'h0155, 16'h02AA}}},
        {JTPG_P_OCTET, JTPG_M_TOGGLE, {3{16'h0000, 16'h00FF}}},
        {JTPG_P_OCTET, JTPG_M_CHECKER, {3{16'h0055, 16'h00AA}}},
        {JTPG_P_SAMPLE, JTPG_M_USER_REP, up[0], up[1], up[2], up[3], up[0], up[1]},
        {JTPG_P_SAMPLE, JTPG_M_USER_ONE, up[0], up[1], up[2], up[3], 32'h0},
        {JTPG_P_SYMBOL, JTPG_M_USER_REP, 96'h0297_0048_03FF_0200_0297_0048},
        {JTPG_P_OCTET, JTPG_M_USER_ONE, 96'h0052_0009_007F_0040_0000_0000},
        {JTPG_P_OCTET, JTPG_M_OFF, 96'h0010_0011_0012_0013_0014_0015}};
    jtpg_top i_dut (.*);
    jtpg_rx_model i_rx (.i_ref_clk(i_ref_clk), .i_clr(clr), .i_point(i_reg.wdata[5:4]),
        .i_frame(o_frame), .i_frame_vld(o_frame_vld), .i_symbol(o_symbol),
        .i_symbol_vld(o_symbol_vld), .i_octet(o_octet), .i_octet_vld(o_octet_vld),
        .o_cap(cap), .o_cnt(cnt));
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_reg = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_ref_clk);
        i_reg.wr = 1'b0;
    endtask
    // read valid stands for one cycle only, so it is looked at right away
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(negedge i_ref_clk);
        i_reg = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: i_reg.wdata};
        @(negedge i_ref_clk);
        i_reg.rd = 1'b0;
        check({15'h0, o_rvalid}, 16'h0001);
        check({8'h00, o_rdata}, {8'h00, exp});
    endtask
    // select, then six back-to-back beats on every point; keeps select in wdata
    task automatic run(input logic [5:0] sel);
        wr(JTPG_ADDR_IF_TEST, {2'b00, sel});
        clr = 1'b1;
        @(negedge i_ref_clk);
        clr = 1'b0;
        for (int k = 0; k < 6; k++) begin
            i_frame = {4{16'h0100 + 16'(k)}};
            i_symbol = 10'h100 + 10'(k);
            i_octet = 8'h10 + 8'(k);
            {i_frame_vld, i_symbol_vld, i_octet_vld} = 3'b111;
            @(negedge i_ref_clk);
        end
        {i_frame_vld, i_symbol_vld, i_octet_vld} = 3'b000;
        @(negedge i_ref_clk);
        check({12'h000, cnt}, 16'h0006);
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        errors++;
        complete_run();
    end
    initial begin
        {i_rst_n, clr, i_frame_vld, i_symbol_vld, i_octet_vld} = 5'b01000;
        {i_reg, i_frame, i_symbol, i_octet} = '0;
        repeat (4) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(JTPG_ADDR_UP_BASE + 12'(2 * k), up[k][15:8]);
            wr(JTPG_ADDR_UP_BASE + 12'(2 * k + 1), up[k][7:0]);
        end
        foreach (rows[i]) begin
            run(rows[i][101:96]);
            for (int k = 0; k < 6; k++) begin
                check(cap[k], rows[i][95 - 16 * k -: 16]);
            end
        end
        // each prbs and the ramp must restart identically when reselected
        for (int m = 3; m <= 8; m++) begin
            run({JTPG_P_OCTET, 4'(m)});
            first = cap;
            run({JTPG_P_OCTET, JTPG_M_OFF});
            run({JTPG_P_OCTET, 4'(m)});
            for (int k = 0; k < 6; k++) begin
                check(cap[k], first[k]);
                if (m == 8) check(cap[k], {8'h00, 8'(cap[0]) + 8'(k)});
            end
        end
        wr(JTPG_ADDR_SYNC_CTRL, JTPG_SYNC_DISABLE);
        check({15'h0, o_sync_req_disable}, 16'h0001);
        rd(JTPG_ADDR_SYNC_CTRL, JTPG_SYNC_DISABLE);
        for (int v = 0; v < 8; v++) begin
            wr(JTPG_ADDR_LL_TEST, 8'(v));
            check({13'h0, o_ll_test_sel}, 16'(v));
            rd(JTPG_ADDR_LL_TEST, 8'(v));
        end
        wr(12'h575, 8'hFF);
        rd(12'h575, 8'h00);
        // reset with a mode live must clear the sync, interface and link layer test registers
        wr(JTPG_ADDR_IF_TEST, {JTPG_P_SYMBOL, JTPG_M_RAMP});
        i_rst_n = 1'b0;
        @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        rd(JTPG_ADDR_IF_TEST, JTPG_RST_IF_TEST);
        rd(JTPG_ADDR_LL_TEST, JTPG_RST_LL_TEST);
        rd(JTPG_ADDR_SYNC_CTRL, JTPG_RST_SYNC_CTRL);
        check({15'h0, o_sync_req_disable}, 16'h0000);
        complete_run();
    end
endmodule
